// file: design/sbcs_supervisor.sv
// Supervisor pin logic: host reset, interrupt, watchdog fault, serial and CAN pins
//
// What this block does
// - Host reset held low 15 ms, or 3.5 ms short variant, after any cause.
// - Interrupt output driven low while any enabled interrupt condition is present.
// - Serial data output floats while chip select is high.
// - Device counts as selected slave only while chip select is low.
// - Watchdog fault output driven low after a watchdog mistrigger.
// - CAN receive data presented to host; host transmit data passed to CAN.
`timescale 1ns/1ps
module sbcs_supervisor
   import sbcs_pkg::*;
#(
   parameter bit SHORT_VARIANT = 1'b0,
   parameter int RST_CYC = SHORT_VARIANT ? RST_SHORT_CYC : RST_LONG_CYC,
   parameter int N_IRQ = IRQ_N
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic vdd_uv,
   input wire logic wd_mistrig,
   input wire logic wd_fault_clr,
   input wire logic [N_IRQ-1:0] irq_cond,
   input wire logic [N_IRQ-1:0] irq_en,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic can_rx_bus,
   input wire logic txd_in,
   output logic rst_out_n_q,
   output logic int_out_n_q,
   output logic wd_fault_out_n_q,
   output logic miso_o,
   output logic miso_oe_q,
   output logic rxd_out_q,
   output logic can_tx_q,
   output logic [7:0] rx_data_q,
   output logic rx_valid_q
);
   localparam logic [RST_CNT_W-1:0] RST_LOAD = RST_CNT_W'(RST_CYC - 1);
   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic uv_m_q, uv_s_q, cs_m_q, cs_s_q;
   logic rx_m_q, rx_s_q, tx_m_q, tx_s_q;
   logic tgl_m_q, tgl_s_q, tgl_p_q;
   logic [7:0] rx_word;
   logic rx_tgl;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         uv_m_q <= 1'b0;
         uv_s_q <= 1'b0;
         cs_m_q <= 1'b1;
         cs_s_q <= 1'b1;
         rx_m_q <= 1'b1;
         rx_s_q <= 1'b1;
         tx_m_q <= 1'b1;
         tx_s_q <= 1'b1;
         tgl_m_q <= 1'b0;
         tgl_s_q <= 1'b0;
         tgl_p_q <= 1'b0;
      end else begin
         uv_m_q <= vdd_uv;
         uv_s_q <= uv_m_q;
         cs_m_q <= cs_n;
         cs_s_q <= cs_m_q;
         rx_m_q <= can_rx_bus;
         rx_s_q <= rx_m_q;
         tx_m_q <= txd_in;
         tx_s_q <= tx_m_q;
         tgl_m_q <= rx_tgl;
         tgl_s_q <= tgl_m_q;
         tgl_p_q <= tgl_s_q;
      end
   end
   // ------------------------------------------------------------------
   // Reset sequencer
   // ------------------------------------------------------------------
   sbcs_rst_state_t st_q, st_d;
   logic [RST_CNT_W-1:0] cnt_q, cnt_d;
   logic rst_out_n_d;
   logic cause;
   assign cause = uv_s_q | wd_mistrig;
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      unique case (st_q)
         SBCS_START: begin
            // Power-up: load the full interval once the reset is gone
            st_d = SBCS_HOLD;
            cnt_d = RST_LOAD;
         end
         SBCS_HOLD: begin
            if (cnt_q == CNT_RST) begin
               st_d = SBCS_RUN;
            end else begin
               cnt_d = cnt_q - RST_CNT_W'(1);
            end
         end
         SBCS_RUN: begin
            cnt_d = CNT_RST;
         end
      endcase
      // A new cause always restarts the interval, even mid-count
      if (cause) begin
         st_d = SBCS_HOLD;
         cnt_d = RST_LOAD;
      end
      rst_out_n_d = (st_d == SBCS_RUN);
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= SBCS_START;
         cnt_q <= CNT_RST;
         rst_out_n_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         rst_out_n_q <= rst_out_n_d;
      end
   end
   // ------------------------------------------------------------------
   // Interrupt and watchdog fault outputs
   // ------------------------------------------------------------------
   logic [N_IRQ-1:0] irq_act;
   logic int_out_n_d, wd_fault_out_n_d;
   genvar gi;
   generate
      for (gi = 0; gi < N_IRQ; gi++) begin : g_irq
         assign irq_act[gi] = irq_cond[gi] & irq_en[gi];
      end
   endgenerate
   always_comb begin
      // Push-pull: both levels driven, no pull-up assumed
      int_out_n_d = ~(|irq_act);
      wd_fault_out_n_d = wd_fault_out_n_q;
      if (wd_fault_clr) begin
         wd_fault_out_n_d = 1'b1;
      end
      // Set wins over a clear in the same cycle
      if (wd_mistrig) begin
         wd_fault_out_n_d = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         int_out_n_q <= 1'b1;
         wd_fault_out_n_q <= 1'b1;
      end else begin
         int_out_n_q <= int_out_n_d;
         wd_fault_out_n_q <= wd_fault_out_n_d;
      end
   end
   // ------------------------------------------------------------------
   // Serial link and CAN data pins
   // ------------------------------------------------------------------
   logic [7:0] tx_status;
   logic [7:0] rx_data_d;
   logic rx_valid_d, rx_new;
   assign tx_status = {4'h0, ~wd_fault_out_n_q, ~int_out_n_q, uv_s_q, ~rst_out_n_q};
   assign rx_new = tgl_s_q ^ tgl_p_q;
   sbcs_spi_link u_link (
      .sclk(sclk),
      .rst_b(rst_b),
      .cs_n(cs_n),
      .mosi(mosi),
      .tx_status(tx_status),
      .miso_q(miso_o),
      .rx_word_q(rx_word),
      .rx_tgl_q(rx_tgl)
   );
   always_comb begin
      // Word is stable for a whole frame after its toggle, so a plain capture is safe
      rx_data_d = rx_new ? rx_word : rx_data_q;
      rx_valid_d = rx_new;
   end
   // Output enable follows deselect three clk cycles late; host must not expect faster turnaround
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         miso_oe_q <= 1'b0;
         rxd_out_q <= 1'b1;
         can_tx_q <= 1'b1;
         rx_data_q <= WORD_RST;
         rx_valid_q <= 1'b0;
      end else begin
         miso_oe_q <= ~cs_s_q;
         rxd_out_q <= rx_s_q;
         can_tx_q <= tx_s_q;
         rx_data_q <= rx_data_d;
         rx_valid_q <= rx_valid_d;
      end
   end
   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   sequence seq_cause;
      cause;
   endsequence
   sequence seq_hold4;
      !rst_out_n_q [*4];
   endsequence
   a_cause_holds_rst: assert property (@(posedge clk) disable iff (!rst_b) seq_cause |=> seq_hold4)
      else $error("reset output released too early after a cause");
   a_release_clean: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(rst_out_n_q) |-> ($past(cnt_q) == CNT_RST) && !$past(cause))
      else $error("reset released before expiry or with a cause active");
   a_restart_count: assert property (@(posedge clk) disable iff (!rst_b) seq_cause |=> (cnt_q == RST_LOAD))
      else $error("interval not restarted on a cause");
   a_int_asserts: assert property (@(posedge clk) disable iff (!rst_b) (|irq_act) |=> !int_out_n_q)
      else $error("enabled interrupt not signalled");
   a_int_idle: assert property (@(posedge clk) disable iff (!rst_b) !(|irq_act) |=> int_out_n_q)
      else $error("interrupt output low with nothing enabled");
   a_wd_fault_low: assert property (@(posedge clk) disable iff (!rst_b)
      wd_mistrig |=> !wd_fault_out_n_q && !rst_out_n_q)
      else $error("watchdog fault not signalled");
   a_miso_float: assert property (@(posedge clk) disable iff (!rst_b) cs_s_q |=> !miso_oe_q)
      else $error("serial output driven while deselected");
   a_miso_select: assert property (@(posedge clk) disable iff (!rst_b) !cs_s_q |=> miso_oe_q)
      else $error("serial output not driven while selected");
   a_can_pass: assert property (@(posedge clk) disable iff (!rst_b)
      ##2 (rxd_out_q == $past(can_rx_bus, 3)) && (can_tx_q == $past(txd_in, 3)))
      else $error("CAN data pin not passed through");
endmodule : sbcs_supervisor

// file: inc/sbcs_pkg.sv
// Constants shared by the supervisor pin logic and its serial link
package sbcs_pkg;
   // ------------------------------------------------------------------
   // Time base
   // ------------------------------------------------------------------
   localparam int CLK_MHZ = 10;
   localparam int RST_LONG_US = 15000;
   localparam int RST_SHORT_US = 3500;
   localparam int RST_LONG_CYC = RST_LONG_US * CLK_MHZ;
   localparam int RST_SHORT_CYC = RST_SHORT_US * CLK_MHZ;
   localparam int RST_CNT_W = 18;
   // ------------------------------------------------------------------
   // Link framing and reset values
   // ------------------------------------------------------------------
   localparam int FRAME_BITS = 8;
   localparam logic [2:0] BIT_CNT_RST = 3'h0;
   localparam logic [7:0] WORD_RST = 8'h00;
   localparam logic [RST_CNT_W-1:0] CNT_RST = 18'h00000;
   localparam int IRQ_N = 4;
   typedef enum logic [2:0] {
      SBCS_START = 3'b001,
      SBCS_HOLD  = 3'b010,
      SBCS_RUN   = 3'b100
   } sbcs_rst_state_t;
endpackage : sbcs_pkg

// file: design/sbcs_spi_link.sv
// Serial slave shifter running on the host serial clock
`timescale 1ns/1ps
module sbcs_spi_link
   import sbcs_pkg::*;
(
   input wire logic sclk,
   input wire logic rst_b,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic [7:0] tx_status,
   output logic miso_q,
   output logic [7:0] rx_word_q,
   output logic rx_tgl_q
);
   // ------------------------------------------------------------------
   // Frame reset
   // ------------------------------------------------------------------
   // Deselect clears the bit position; sclk may stand still outside frames
   logic frame_rst_b;
   assign frame_rst_b = rst_b & ~cs_n;
   logic [2:0] bit_cnt_q, bit_cnt_d;
   logic [7:0] shift_q, shift_d;
   logic [7:0] rx_word_d;
   logic rx_tgl_d;
   logic [7:0] st_m_q, st_s_q;
   // ------------------------------------------------------------------
   // Status crossing, bitwise quasi-static levels
   // ------------------------------------------------------------------
   always_ff @(posedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         st_m_q <= WORD_RST;
         st_s_q <= WORD_RST;
      end else begin
         st_m_q <= tx_status;
         st_s_q <= st_m_q;
      end
   end
   // Launch on rising edge, host clock only, never generated here
   always_ff @(posedge sclk or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         miso_q <= 1'b0;
      end else begin
         miso_q <= st_s_q[3'h7 - bit_cnt_q];
      end
   end
   // ------------------------------------------------------------------
   // Capture on falling edge
   // ------------------------------------------------------------------
   always_comb begin
      bit_cnt_d = bit_cnt_q + 3'h1;
      shift_d = {shift_q[6:0], mosi};
      rx_word_d = rx_word_q;
      rx_tgl_d = rx_tgl_q;
      if (bit_cnt_q == 3'(FRAME_BITS - 1)) begin
         rx_word_d = {shift_q[6:0], mosi};
         rx_tgl_d = ~rx_tgl_q;
      end
   end
   always_ff @(negedge sclk or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         bit_cnt_q <= BIT_CNT_RST;
         shift_q <= WORD_RST;
      end else begin
         bit_cnt_q <= bit_cnt_d;
         shift_q <= shift_d;
      end
   end
   always_ff @(negedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         rx_word_q <= WORD_RST;
         rx_tgl_q <= 1'b0;
      end else begin
         rx_word_q <= rx_word_d;
         rx_tgl_q <= rx_tgl_d;
      end
   end
   a_frame_toggle: assert property (@(negedge sclk) disable iff (!frame_rst_b)
      (bit_cnt_q == 3'h7) |=> (rx_tgl_q != $past(rx_tgl_q)))
      else $error("word end did not toggle");
endmodule : sbcs_spi_link

// file: test/sbcs_host_model.sv
// Host controller model: master of the serial link
`timescale 1ns/1ps
module sbcs_host_model (
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso
);
   // ---------------------------------------
   // Serial master, mode 1
   // ---------------------------------------
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // Clock stands low outside frames; long gaps keep the slow core in step
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      // Start off the core clock edge so chip select never races its synchroniser
      #3;
      cs_n = 1'b0;
      #500;
      for (int i = 7; i >= 0; i--) begin
         sclk = 1'b1;
         mosi = tx[i];
         #7.5;
         sclk = 1'b0;
         rx[i] = miso;
         #7.5;
      end
      #600;
      mosi = ~mosi;
      cs_n = 1'b1;
      #500;
   endtask : xfer
   // Cut frame: a few bits, then deselect; the slave must drop them
   task automatic cut(input int nbits);
      #3;
      cs_n = 1'b0;
      #500;
      for (int i = 0; i < nbits; i++) begin
         sclk = 1'b1;
         mosi = ~mosi;
         #7.5;
         sclk = 1'b0;
         #7.5;
      end
      #100;
      cs_n = 1'b1;
      #500;
   endtask : cut
   // Two bytes in one frame; the pause lets the core take the first byte
   task automatic burst(input logic [15:0] tx, output logic [15:0] rx);
      #3;
      cs_n = 1'b0;
      #500;
      for (int i = 15; i >= 0; i--) begin
         sclk = 1'b1;
         mosi = tx[i];
         #7.5;
         sclk = 1'b0;
         rx[i] = miso;
         #7.5;
         if (i == 8) begin
            #500;
         end
      end
      #600;
      mosi = ~mosi;
      cs_n = 1'b1;
      #500;
   endtask : burst
endmodule : sbcs_host_model

// file: test/test_sbcs_supervisor.sv
// Self-checking testbench of the supervisor pin logic
`timescale 1ns/1ps
module test_sbcs_supervisor;
   import sbcs_pkg::*;
   localparam int RC = 20;
   logic clk, rst_b, vdd_uv, wd_mistrig, wd_fault_clr, can_rx_bus, txd_in;
   logic [3:0] irq_cond, irq_en, p;
   logic sclk, cs_n, mosi, miso_w, miso_o, miso_oe_q;
   logic rst_out_n_q, int_out_n_q, wd_fault_out_n_q, rxd_out_q, can_tx_q, rx_valid_q;
   logic [7:0] rx_data_q, tb, rb;
   logic [15:0] tw, rw;
   int fails, samples_checked, seed, nval, n0;
   // ---------------------------------------
   // Clock, design, host and helpers
   // ---------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // MISO floats unless the slave enables it, so a float shows as a mismatch
   assign miso_w = miso_oe_q ? miso_o : 1'bz;
   sbcs_supervisor #(.RST_CYC(RC)) dut_u (.clk(clk), .rst_b(rst_b), .vdd_uv(vdd_uv),
      .wd_mistrig(wd_mistrig), .wd_fault_clr(wd_fault_clr), .irq_cond(irq_cond),
      .irq_en(irq_en), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .can_rx_bus(can_rx_bus),
      .txd_in(txd_in), .rst_out_n_q(rst_out_n_q), .int_out_n_q(int_out_n_q),
      .wd_fault_out_n_q(wd_fault_out_n_q), .miso_o(miso_o), .miso_oe_q(miso_oe_q),
      .rxd_out_q(rxd_out_q), .can_tx_q(can_tx_q), .rx_data_q(rx_data_q), .rx_valid_q(rx_valid_q));
   sbcs_host_model host_u (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_w));
   always @(posedge clk) if (rx_valid_q === 1'b1) nval++;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Status byte the slave should shift out, bit 7 first
   function automatic logic [7:0] exp_status(input logic wd, input logic irq, input logic uv, input logic rst);
      exp_status = {4'h0, wd, irq, uv, rst};
   endfunction : exp_status
   // Interrupt pin level expected one edge after the enabled conditions
   function automatic logic [7:0] exp_int(input logic [3:0] act);
      exp_int = {7'h00, ~|act};
   endfunction : exp_int
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   // Reset output must stay low through edge n, then rise on the next one
   task automatic rel_check(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk) check(rst_out_n_q, 8'h00);
      @(posedge clk);
      @(negedge clk) check(rst_out_n_q, 8'h01);
   endtask : rel_check
   initial begin
      #200000;
      fails++;
      finish_test();
   end
   // ---------------------------------------
   // Scenarios
   // ---------------------------------------
   initial begin
      seed = 66;
      {rst_b, vdd_uv, wd_mistrig, wd_fault_clr, can_rx_bus, txd_in} = 6'h03;
      irq_cond = 4'h0;
      irq_en = 4'h0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      rel_check(RC);
      // Mistrigger with a clear in the same cycle: the clear must lose
      @(posedge clk) {wd_mistrig, wd_fault_clr} <= 2'h3;
      @(posedge clk) {wd_mistrig, wd_fault_clr} <= 2'h0;
      @(negedge clk) check({wd_fault_out_n_q, rst_out_n_q}, 8'h00);
      rel_check(RC - 1);
      check(wd_fault_out_n_q, 8'h00);
      @(posedge clk) wd_fault_clr <= 1'b1;
      @(posedge clk) wd_fault_clr <= 1'b0;
      @(negedge clk) check(wd_fault_out_n_q, 8'h01);
      for (int i = 0; i < 60; i++) begin
         @(posedge clk);
         p = irq_cond & irq_en;
         irq_cond <= 4'($random(seed));
         irq_en <= (i < 3) ? 4'h0 : 4'($random(seed));
         if (i % 6 == 0) {can_rx_bus, txd_in} <= 2'($random(seed));
         @(negedge clk) check(int_out_n_q, exp_int(p));
         if (i % 6 == 5) check({rxd_out_q, can_tx_q}, {can_rx_bus, txd_in});
      end
      // Undervoltage held: reset stays low, status byte shows undervoltage and interrupt
      @(posedge clk);
      vdd_uv <= 1'b1;
      irq_cond <= 4'h1;
      irq_en <= 4'h1;
      repeat (6) @(posedge clk);
      n0 = nval;
      tb = 8'($random(seed));
      host_u.xfer(tb, rb);
      check(rb, exp_status(1'b0, 1'b1, 1'b1, 1'b1));
      check(rx_data_q, tb);
      check(8'(nval - n0), 8'h01);
      check(miso_oe_q, 8'h00);
      // Cut frame must leave no trace, then two bytes share one frame
      n0 = nval;
      host_u.cut(3);
      tw = 16'($random(seed));
      host_u.burst(tw, rw);
      check(rw[15:8], exp_status(1'b0, 1'b1, 1'b1, 1'b1));
      check(rw[7:0], exp_status(1'b0, 1'b1, 1'b1, 1'b1));
      check(rx_data_q, tw[7:0]);
      check(8'(nval - n0), 8'h02);
      check(miso_oe_q, 8'h00);
      repeat (RC + 5) @(posedge clk);
      @(negedge clk) check(rst_out_n_q, 8'h00);
      @(posedge clk) vdd_uv <= 1'b0;
      rel_check(RC + 1);
      finish_test();
   end
endmodule : test_sbcs_supervisor
